// *** bench/swsc_mcu_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Controller side: framed state commands and enable writes, driven on falling edges
module swsc_mcu_model (
  input  wire logic       clk_i,
  output logic            frame_end_o,
  output logic            state_req_o,
  output logic [1:0]      state_code_o,
  output logic [4:0]      sleep_reg_o,
  output logic [2:0]      sleep_sup_o,
  output logic            reg_wr_o,
  output logic [4:0]      reg_wdata_o,
  output logic            sup_wr_o,
  output logic [2:0]      sup_wdata_o
);
  // Idle bus at time zero
  initial begin
    {frame_end_o, state_req_o, reg_wr_o, sup_wr_o} = 4'h0;
    {state_code_o, sleep_reg_o, sleep_sup_o, reg_wdata_o, sup_wdata_o} = 18'h0;
  end

  // One-cycle frame; fe low stands for a frame whose select edge was not valid
  task automatic send_cmd(input logic [1:0] code, input logic [4:0] rcfg,
                          input logic [2:0] scfg, input logic fe);
    @(negedge clk_i);
    {state_req_o, frame_end_o, state_code_o} = {1'b1, fe, code};
    {sleep_reg_o, sleep_sup_o} = {rcfg, scfg};
    @(negedge clk_i);
    {state_req_o, frame_end_o, state_code_o} = {2'b00, ~code};
    // Released lines show the inverse, so a stale capture cannot pass
    {sleep_reg_o, sleep_sup_o} = ~{rcfg, scfg};
  endtask

  // Regulator and tracker switch command
  task automatic reg_write(input logic [4:0] d);
    @(negedge clk_i);
    {reg_wr_o, reg_wdata_o} = {1'b1, d};
    @(negedge clk_i);
    {reg_wr_o, reg_wdata_o} = {1'b0, ~d};
  endtask

  // Supervision switch command
  task automatic sup_write(input logic [2:0] d);
    @(negedge clk_i);
    {sup_wr_o, sup_wdata_o} = {1'b1, d};
    @(negedge clk_i);
    {sup_wr_o, sup_wdata_o} = {1'b0, ~d};
  endtask
endmodule // swsc_mcu_model
`default_nettype wire

// *** bench/tb_sleep_wake_state_control.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_sleep_wake_state_control;
  logic       clk, nrst, seq, core_pin, tmr_en, step_pin, in_low;
  logic [7:0] ev;
  logic       fe, sreq, wr, swr;
  logic [1:0] code;
  logic [4:0] scfg_r, wd, reg_en, flags;
  logic [2:0] scfg_s, swd, state, sup_en;
  logic       step_dn, step_up, ctrl_en, cur_mon, core_adj, tmr_run;
  logic       rst_n, safe_state_control, ss1, ss2, alert;
  int         failures, n_compared, cyc, k;

  swsc_mcu_model MCU (.clk_i(clk), .frame_end_o(fe), .state_req_o(sreq),
    .state_code_o(code), .sleep_reg_o(scfg_r), .sleep_sup_o(scfg_s), .reg_wr_o(wr),
    .reg_wdata_o(wd), .sup_wr_o(swr), .sup_wdata_o(swd));

  // Event inputs: 0 current,1 primary,2 level,3 self test,4 timer,5 trans,6 normal,7 clear
  swsc_top DUT (.REF_CLK_I(clk), .NRST_I(nrst), .SEQUENCING_I(seq),
    .NORMAL_ENTRY_I(ev[6]), .FRAME_END_I(fe), .STATE_REQ_I(sreq), .STATE_CODE_I(code),
    .SLEEP_REG_CFG_I(scfg_r), .SLEEP_SUP_CFG_I(scfg_s), .REG_WR_I(wr), .REG_WDATA_I(wd),
    .SUP_WR_I(swr), .SUP_WDATA_I(swd), .TIMER_CFG_EN_I(tmr_en), .TIMER_EXPIRED_I(ev[4]),
    .SELF_TEST_I(ev[3]), .TRANS_DONE_I(ev[5]), .CURRENT_HIGH_I(ev[0]),
    .PRIMARY_WAKE_I(ev[1]), .LEVEL_RESUME_I(ev[2]), .STEP_UP_SELECT_PIN_I(step_pin),
    .INPUT_LOW_I(in_low), .CORE_SUPPLY_SELECT_PIN_I(core_pin), .FLAGS_CLR_I(ev[7]),
    .STATE_O(state), .REG_EN_O(reg_en), .SUP_EN_O(sup_en), .PRE_REG_STEP_DOWN_O(step_dn),
    .PRE_REG_STEP_UP_O(step_up), .CTRL_REG_EN_O(ctrl_en), .CURRENT_MON_EN_O(cur_mon),
    .CORE_SUPPLY_ADJUST_O(core_adj), .TIMER_RUN_O(tmr_run), .RESET_N_O(rst_n),
    .SAFE_STATE_CONTROL_O(safe_state_control), .SAFE_STATE_ONE_O(ss1), .SAFE_STATE_TWO_O(ss2),
    .ALERT_O(alert), .RESUME_SOURCE_FLAGS_O(flags));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard: the whole sequence needs well under 400 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic chk(input string n, input logic [4:0] e, input logic [4:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic st(input swsc_pkg::swsc_state_t s);
    chk("state", 5'(s), 5'(state));
  endtask

  // One-cycle event; outputs are settled at the falling edge where this returns
  task automatic pulse(input int i);
    @(negedge clk);
    ev[i] = 1'b1;
    @(negedge clk);
    ev[i] = 1'b0;
  endtask

  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    {nrst, ev, failures, n_compared, cyc} = '0;
    {seq, core_pin, tmr_en, step_pin, in_low} = 5'h1f;
    repeat (8) @(negedge clk);
    st(swsc_pkg::SWSC_OTHER);
    chk("sup_rst", 5'(swsc_pkg::SWSC_SUP_RST), 5'(sup_en));
    nrst = 1'b1;
    @(negedge clk);
    {seq, core_pin} = 2'b00;
    pulse(6);
    st(swsc_pkg::SWSC_NORMAL);
    chk("safe_normal", 5'h07, 5'({safe_state_control, ss1, ss2}));
    MCU.reg_write(5'h1b);
    MCU.sup_write(3'h3);
    chk("reg_normal", 5'h1b, reg_en);
    MCU.send_cmd(swsc_pkg::SWSC_REQ_SLEEP, 5'h04, 3'h4, 1'b0);
    st(swsc_pkg::SWSC_NORMAL);
    MCU.send_cmd(swsc_pkg::SWSC_REQ_SLEEP, 5'h04, 3'h4, 1'b1);
    st(swsc_pkg::SWSC_TRANS);
    chk("reg_trans", 5'h05, reg_en);
    MCU.reg_write(5'h00);
    pulse(5);
    st(swsc_pkg::SWSC_SLEEP);
    chk("reg_sleep", 5'h05, reg_en);
    chk("sup_sleep", 5'h04, 5'(sup_en));
    chk("timer_sleep", 5'h01, 5'(tmr_run));
    chk("rst_sleep", 5'h01, 5'(rst_n));
    chk("safe_sleep", 5'h00, 5'({safe_state_control, ss1, ss2}));
    chk("pre_regulator", 5'h03, 5'({step_dn, step_up}));
    chk("ctrl_reg", 5'h01, 5'(ctrl_en));
    chk("cur_mon", 5'h01, 5'(cur_mon));
    chk("core_adj", 5'h01, 5'(core_adj));
    $display("test sleep_entry done");
    // Every exit cause in turn, back to sleep after each
    for (k = 0; k < 5; k++) begin
      pulse(7);
      if (k == 3) MCU.send_cmd(swsc_pkg::SWSC_REQ_WAKE, 5'h00, 3'h0, 1'b1);
      else pulse(k);
      st(swsc_pkg::SWSC_WAKE);
      chk("alert", 5'h01, 5'(alert));
      chk("flags", 5'(1 << k), flags);
      chk("reg_wake", 5'h1b, reg_en);
      chk("sup_wake", 5'h03, 5'(sup_en));
      chk("timer_wake", 5'h00, 5'(tmr_run));
      chk("wake_pins", 5'h08, 5'({rst_n, safe_state_control, ss1, ss2}));
      @(negedge clk);
      chk("alert_end", 5'h00, 5'(alert));
      MCU.send_cmd(swsc_pkg::SWSC_REQ_SLEEP, 5'h04, 3'h4, 1'b1);
      pulse(5);
    end
    $display("test wake_causes done");
    MCU.send_cmd(swsc_pkg::SWSC_REQ_WAKE, 5'h00, 3'h0, 1'b1);
    MCU.reg_write(5'h0a);
    chk("reg_wake_wr", 5'h0a, reg_en);
    MCU.sup_write(3'h2);
    chk("sup_wake_wr", 5'h02, 5'(sup_en));
    MCU.send_cmd(swsc_pkg::SWSC_REQ_NORMAL, 5'h00, 3'h0, 1'b1);
    st(swsc_pkg::SWSC_NORMAL);
    pulse(3);
    st(swsc_pkg::SWSC_WAKE);
    chk("alert_test", 5'h01, 5'(alert));
    MCU.send_cmd(swsc_pkg::SWSC_REQ_SLEEP, 5'h04, 3'h4, 1'b1);
    pulse(7);
    pulse(2);
    st(swsc_pkg::SWSC_WAKE);
    chk("flags_trans", 5'h04, flags);
    MCU.send_cmd(swsc_pkg::SWSC_REQ_STANDBY, 5'h00, 3'h0, 1'b1);
    st(swsc_pkg::SWSC_STANDBY);
    $display("test wake_controls done");
    // Mid-run reset: everything drops back to its idle values
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    st(swsc_pkg::SWSC_OTHER);
    chk("reg_rst", 5'h00, reg_en);
    chk("flags_rst", 5'h00, flags);
    chk("pins_rst", 5'h00, 5'({rst_n, safe_state_control, alert, cur_mon, tmr_run}));
    chk("sup_rst2", 5'(swsc_pkg::SWSC_SUP_RST), 5'(sup_en));
    $display("test mid_reset done");
    wrap_up();
  end
endmodule // tb_sleep_wake_state_control
`default_nettype wire

// *** common/swsc_pkg.sv ***
package swsc_pkg;
  // Top-level states this block distinguishes; others are handled elsewhere
  typedef enum logic [2:0] {
    SWSC_OTHER,
    SWSC_NORMAL,
    SWSC_TRANS,
    SWSC_SLEEP,
    SWSC_WAKE,
    SWSC_STANDBY
  } swsc_state_t;

  // Requested state codes carried with a state-change command
  localparam logic [1:0] SWSC_REQ_NORMAL  = 2'h0;
  localparam logic [1:0] SWSC_REQ_SLEEP   = 2'h1;
  localparam logic [1:0] SWSC_REQ_STANDBY = 2'h2;
  localparam logic [1:0] SWSC_REQ_WAKE    = 2'h3;

  // Regulator enable vector layout
  localparam int SWSC_REG_W    = 5;
  localparam int SWSC_BIT_STBY = 0;
  localparam int SWSC_BIT_COMM = 1;
  localparam int SWSC_BIT_REF  = 2;
  localparam int SWSC_BIT_TRK1 = 3;
  localparam int SWSC_BIT_TRK2 = 4;
  localparam logic [4:0] SWSC_REG_RST = 5'h00;

  // Supervision vector: window dog, functional dog, error monitor
  localparam int SWSC_SUP_W    = 3;
  localparam logic [2:0] SWSC_SUP_RST = 3'h5;

  // Resume source flag layout
  localparam int SWSC_SRC_W     = 5;
  localparam int SWSC_SRC_CURR  = 0;
  localparam int SWSC_SRC_PRIM  = 1;
  localparam int SWSC_SRC_LEVEL = 2;
  localparam int SWSC_SRC_CMD   = 3;
  localparam int SWSC_SRC_TIMER = 4;
  localparam logic [4:0] SWSC_SRC_RST = 5'h00;
endpackage

// *** verilog/swsc_top.sv ***
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Standby regulator in sleep keeps the setting it had before sleep.
// - Step-down stage on in sleep/wake; step-up only if pin and input need it.
// - Controller regulator on in sleep; overcurrent raises alert and goes to wake.
// - Comm regulator takes sleep-request setting, frozen during sleep.
// - Reference regulator takes sleep-request setting; writes ignored in sleep.
// - Both trackers take sleep-request setting, frozen until sleep ends.
// - Core supply adjust follows its select pin only during power sequencing.
// - Wake-up timer runs in sleep per its configured enable.
// - Watchdogs in sleep follow the stored sleep configuration.
// - Error monitor in sleep follows the stored sleep configuration.
// - Reset output stays high in sleep and wake.
// - Safe-state outputs stay low in sleep and wake.
// - Current, wake inputs or resume command move sleep or transition to wake.
// - Analog self test from normal moves the device to wake.
// - Every wake entry pulses the alert output.
// - Supervision on wake entry returns to its pre-sleep normal condition.
// - Regulator settings on wake entry return to pre-sleep normal values.
// - In wake, regulator and tracker writes apply immediately.
// - In wake, supervision writes are accepted and applied.
// - Wake-up timer is stopped in wake regardless of its enable.
// - From wake, sleep, standby and normal requests are accepted.
// - Commanded state changes apply only on the select rising edge ending a frame.
// - Enabled wake-up timer expiry in sleep moves to wake.
// - The exit cause from sleep is recorded in resume source flags.
module swsc_top (
  input  wire logic                               REF_CLK_I,
  input  wire logic                               NRST_I,
  input  wire logic                               SEQUENCING_I,
  input  wire logic                               NORMAL_ENTRY_I,
  input  wire logic                               FRAME_END_I,
  input  wire logic                               STATE_REQ_I,
  input  wire logic [1:0]                         STATE_CODE_I,
  input  wire logic [swsc_pkg::SWSC_REG_W-1:0]    SLEEP_REG_CFG_I,
  input  wire logic [swsc_pkg::SWSC_SUP_W-1:0]    SLEEP_SUP_CFG_I,
  input  wire logic                               REG_WR_I,
  input  wire logic [swsc_pkg::SWSC_REG_W-1:0]    REG_WDATA_I,
  input  wire logic                               SUP_WR_I,
  input  wire logic [swsc_pkg::SWSC_SUP_W-1:0]    SUP_WDATA_I,
  input  wire logic                               TIMER_CFG_EN_I,
  input  wire logic                               TIMER_EXPIRED_I,
  input  wire logic                               SELF_TEST_I,
  input  wire logic                               TRANS_DONE_I,
  input  wire logic                               CURRENT_HIGH_I,
  input  wire logic                               PRIMARY_WAKE_I,
  input  wire logic                               LEVEL_RESUME_I,
  input  wire logic                               STEP_UP_SELECT_PIN_I,
  input  wire logic                               INPUT_LOW_I,
  input  wire logic                               CORE_SUPPLY_SELECT_PIN_I,
  input  wire logic                               FLAGS_CLR_I,
  output logic [2:0]                              STATE_O,
  output logic [swsc_pkg::SWSC_REG_W-1:0]         REG_EN_O,
  output logic [swsc_pkg::SWSC_SUP_W-1:0]         SUP_EN_O,
  output logic                                    PRE_REG_STEP_DOWN_O,
  output logic                                    PRE_REG_STEP_UP_O,
  output logic                                    CTRL_REG_EN_O,
  output logic                                    CURRENT_MON_EN_O,
  output logic                                    CORE_SUPPLY_ADJUST_O,
  output logic                                    TIMER_RUN_O,
  output logic                                    RESET_N_O,
  output logic                                    SAFE_STATE_CONTROL_O,
  output logic                                    SAFE_STATE_ONE_O,
  output logic                                    SAFE_STATE_TWO_O,
  output logic                                    ALERT_O,
  output logic [swsc_pkg::SWSC_SRC_W-1:0]         RESUME_SOURCE_FLAGS_O
);

  swsc_pkg::swsc_state_t state_reg, state_next;
  logic [swsc_pkg::SWSC_REG_W-1:0] reg_en_reg, reg_en_next;
  logic [swsc_pkg::SWSC_REG_W-1:0] norm_reg_reg, norm_reg_next;
  logic [swsc_pkg::SWSC_SUP_W-1:0] sup_en_reg, sup_en_next;
  logic [swsc_pkg::SWSC_SUP_W-1:0] norm_sup_reg, norm_sup_next;
  logic [swsc_pkg::SWSC_SRC_W-1:0] flags_reg, flags_next;
  logic                            core_reg, core_next;
  logic                            step_up_reg, step_up_next;
  logic                            timer_run_reg, timer_run_next;
  logic                            alert_reg, alert_next;
  logic                            live_reg, live_next;
  logic                            cmd_ok;
  logic [swsc_pkg::SWSC_SRC_W-1:0] wake_src;
  logic                            wake_ev;

  // Commands count only when the frame's select edge arrives
  assign cmd_ok = STATE_REQ_I & FRAME_END_I;

  // Resume causes, one bit each
  always_comb begin
    wake_src = '0;
    wake_src[swsc_pkg::SWSC_SRC_CURR]  = CURRENT_HIGH_I;
    wake_src[swsc_pkg::SWSC_SRC_PRIM]  = PRIMARY_WAKE_I;
    wake_src[swsc_pkg::SWSC_SRC_LEVEL] = LEVEL_RESUME_I;
    wake_src[swsc_pkg::SWSC_SRC_CMD]   = cmd_ok & (STATE_CODE_I == swsc_pkg::SWSC_REQ_WAKE);
    wake_src[swsc_pkg::SWSC_SRC_TIMER] = TIMER_EXPIRED_I & TIMER_CFG_EN_I
                                         & (state_reg == swsc_pkg::SWSC_SLEEP);
    wake_ev = |wake_src;
  end

  // State machine and setting copies
  always_comb begin
    state_next    = state_reg;
    reg_en_next   = reg_en_reg;
    norm_reg_next = norm_reg_reg;
    sup_en_next   = sup_en_reg;
    norm_sup_next = norm_sup_reg;
    flags_next    = flags_reg;
    alert_next    = 1'b0;
    live_next     = live_reg;
    case (state_reg)
      swsc_pkg::SWSC_OTHER: begin
        if (NORMAL_ENTRY_I) begin
          state_next = swsc_pkg::SWSC_NORMAL;
          live_next  = 1'b1;
        end
      end
      swsc_pkg::SWSC_NORMAL: begin
        if (REG_WR_I) begin
          reg_en_next = REG_WDATA_I;
        end
        if (SUP_WR_I) begin
          sup_en_next = SUP_WDATA_I;
        end
        if (SELF_TEST_I) begin
          state_next = swsc_pkg::SWSC_WAKE;
          alert_next = 1'b1;
        end else if (cmd_ok && STATE_CODE_I == swsc_pkg::SWSC_REQ_SLEEP) begin
          // Keep normal copy, load sleep settings at the accepting edge
          norm_reg_next = reg_en_reg;
          norm_sup_next = sup_en_reg;
          reg_en_next   = SLEEP_REG_CFG_I;
          reg_en_next[swsc_pkg::SWSC_BIT_STBY] = reg_en_reg[swsc_pkg::SWSC_BIT_STBY];
          sup_en_next   = SLEEP_SUP_CFG_I;
          state_next    = swsc_pkg::SWSC_TRANS;
        end else if (cmd_ok && STATE_CODE_I == swsc_pkg::SWSC_REQ_STANDBY) begin
          state_next = swsc_pkg::SWSC_STANDBY;
        end
      end
      swsc_pkg::SWSC_TRANS, swsc_pkg::SWSC_SLEEP: begin
        // Writes are ignored here; settings stay frozen until exit
        if (wake_ev) begin
          state_next  = swsc_pkg::SWSC_WAKE;
          alert_next  = 1'b1;
          reg_en_next = norm_reg_reg;
          sup_en_next = norm_sup_reg;
          flags_next  = flags_reg | wake_src;
        end else if (state_reg == swsc_pkg::SWSC_TRANS && TRANS_DONE_I) begin
          state_next = swsc_pkg::SWSC_SLEEP;
        end
      end
      swsc_pkg::SWSC_WAKE: begin
        if (REG_WR_I) begin
          reg_en_next = REG_WDATA_I;
        end
        if (SUP_WR_I) begin
          sup_en_next = SUP_WDATA_I;
        end
        if (cmd_ok && STATE_CODE_I == swsc_pkg::SWSC_REQ_NORMAL) begin
          state_next = swsc_pkg::SWSC_NORMAL;
        end else if (cmd_ok && STATE_CODE_I == swsc_pkg::SWSC_REQ_SLEEP) begin
          norm_reg_next = reg_en_reg;
          norm_sup_next = sup_en_reg;
          reg_en_next   = SLEEP_REG_CFG_I;
          reg_en_next[swsc_pkg::SWSC_BIT_STBY] = reg_en_reg[swsc_pkg::SWSC_BIT_STBY];
          sup_en_next   = SLEEP_SUP_CFG_I;
          state_next    = swsc_pkg::SWSC_TRANS;
        end else if (cmd_ok && STATE_CODE_I == swsc_pkg::SWSC_REQ_STANDBY) begin
          state_next = swsc_pkg::SWSC_STANDBY;
        end
      end
      default: begin
        // Standby exit is outside this block
        state_next = state_reg;
      end
    endcase
    // Clear by software, but a new cause in the same cycle wins
    if (FLAGS_CLR_I) begin
      flags_next = wake_ev && (state_reg == swsc_pkg::SWSC_SLEEP ||
                               state_reg == swsc_pkg::SWSC_TRANS) ? wake_src : '0;
    end
  end

  // Pin-derived and state-derived enables
  always_comb begin
    core_next      = SEQUENCING_I ? CORE_SUPPLY_SELECT_PIN_I : core_reg;
    step_up_next   = STEP_UP_SELECT_PIN_I & INPUT_LOW_I;
    timer_run_next = (state_next == swsc_pkg::SWSC_SLEEP) & TIMER_CFG_EN_I;
  end

  // Registers
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      state_reg     <= swsc_pkg::SWSC_OTHER;
      reg_en_reg    <= swsc_pkg::SWSC_REG_RST;
      norm_reg_reg  <= swsc_pkg::SWSC_REG_RST;
      sup_en_reg    <= swsc_pkg::SWSC_SUP_RST;
      norm_sup_reg  <= swsc_pkg::SWSC_SUP_RST;
      flags_reg     <= swsc_pkg::SWSC_SRC_RST;
      core_reg      <= 1'b0;
      step_up_reg   <= 1'b0;
      timer_run_reg <= 1'b0;
      alert_reg     <= 1'b0;
      live_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      reg_en_reg    <= reg_en_next;
      norm_reg_reg  <= norm_reg_next;
      sup_en_reg    <= sup_en_next;
      norm_sup_reg  <= norm_sup_next;
      flags_reg     <= flags_next;
      core_reg      <= core_next;
      step_up_reg   <= step_up_next;
      timer_run_reg <= timer_run_next;
      alert_reg     <= alert_next;
      live_reg      <= live_next;
    end
  end

  // Outputs straight from flip-flops; safe-state high only in normal
  logic ss_reg, ss_next, rst_reg, rst_next, on_reg, on_next;
  logic cur_mon_reg, cur_mon_next;
  always_comb begin
    ss_next      = (state_next == swsc_pkg::SWSC_NORMAL);
    rst_next     = live_next & (state_next != swsc_pkg::SWSC_STANDBY);
    on_next      = live_next & (state_next != swsc_pkg::SWSC_STANDBY);
    // Load current is watched in the transition, sleep and wake states
    cur_mon_next = (state_next == swsc_pkg::SWSC_TRANS) |
                   (state_next == swsc_pkg::SWSC_SLEEP) |
                   (state_next == swsc_pkg::SWSC_WAKE);
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      ss_reg      <= 1'b0;
      rst_reg     <= 1'b0;
      on_reg      <= 1'b0;
      cur_mon_reg <= 1'b0;
    end else begin
      ss_reg      <= ss_next;
      rst_reg     <= rst_next;
      on_reg      <= on_next;
      cur_mon_reg <= cur_mon_next;
    end
  end

  assign STATE_O               = state_reg;
  assign REG_EN_O              = reg_en_reg;
  assign SUP_EN_O              = sup_en_reg;
  assign PRE_REG_STEP_DOWN_O   = on_reg;
  assign PRE_REG_STEP_UP_O     = step_up_reg;
  assign CTRL_REG_EN_O         = on_reg;
  assign CURRENT_MON_EN_O      = cur_mon_reg;
  assign CORE_SUPPLY_ADJUST_O  = core_reg;
  assign TIMER_RUN_O           = timer_run_reg;
  assign RESET_N_O             = rst_reg;
  assign SAFE_STATE_CONTROL_O  = ss_reg;
  assign SAFE_STATE_ONE_O      = ss_reg;
  assign SAFE_STATE_TWO_O      = ss_reg;
  assign ALERT_O               = alert_reg;
  assign RESUME_SOURCE_FLAGS_O = flags_reg;

  // Checks
  AST_WAKE_ALERT: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_reg != swsc_pkg::SWSC_WAKE) ##1 (state_reg == swsc_pkg::SWSC_WAKE) |-> ALERT_O)
    else $error("No alert on wake entry");
  AST_RESTORE: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_reg == swsc_pkg::SWSC_SLEEP && wake_ev) |=> (REG_EN_O == $past(norm_reg_reg)))
    else $error("Regulators not restored");
  AST_SUP_RESTORE: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_reg == swsc_pkg::SWSC_SLEEP && wake_ev) |=> (SUP_EN_O == $past(norm_sup_reg)))
    else $error("Supervision not restored");
  AST_FROZEN: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_reg == swsc_pkg::SWSC_SLEEP && !wake_ev) |=> $stable(REG_EN_O))
    else $error("Settings changed in sleep");
  AST_TIMER_WAKE: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_reg == swsc_pkg::SWSC_WAKE) ##1 (state_reg == swsc_pkg::SWSC_WAKE) |-> !TIMER_RUN_O)
    else $error("Timer runs in wake");
  AST_SAFE_LOW: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_reg == swsc_pkg::SWSC_SLEEP) |-> !SAFE_STATE_ONE_O && !SAFE_STATE_TWO_O)
    else $error("Safe state high in sleep");
  AST_RESET_HIGH: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_reg == swsc_pkg::SWSC_WAKE) |-> RESET_N_O)
    else $error("Reset asserted in wake");
  AST_CMD_EDGE: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_reg == swsc_pkg::SWSC_NORMAL && !FRAME_END_I && !SELF_TEST_I)
      |=> state_reg == swsc_pkg::SWSC_NORMAL)
    else $error("State changed without frame end");
  AST_FLAGS: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_reg == swsc_pkg::SWSC_SLEEP && CURRENT_HIGH_I)
      |=> RESUME_SOURCE_FLAGS_O[swsc_pkg::SWSC_SRC_CURR])
    else $error("Current cause not recorded");

  // Sleep keeps the controller supply and its load monitor running
  AST_CUR_MON: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_reg == swsc_pkg::SWSC_SLEEP) |-> CURRENT_MON_EN_O && CTRL_REG_EN_O)
    else $error("Controller supply or monitor off in sleep");

  // Step-down stage never drops out in the low-power pair of states
  AST_STEP_DOWN: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_reg == swsc_pkg::SWSC_SLEEP || state_reg == swsc_pkg::SWSC_WAKE)
      |-> PRE_REG_STEP_DOWN_O)
    else $error("Step-down stage off in sleep or wake");

  // Step-up only follows a selected pin and a low input
  AST_STEP_UP: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    PRE_REG_STEP_UP_O |-> $past(STEP_UP_SELECT_PIN_I) && $past(INPUT_LOW_I))
    else $error("Step-up stage on without selection");

  // The select pin is ignored once sequencing is over
  AST_CORE_HOLD: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    !SEQUENCING_I |=> $stable(CORE_SUPPLY_ADJUST_O))
    else $error("Core supply adjust moved outside sequencing");

  // Timer in sleep runs exactly as configured
  AST_TIMER_SLEEP: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_reg == swsc_pkg::SWSC_SLEEP) |-> TIMER_RUN_O == $past(TIMER_CFG_EN_I))
    else $error("Timer run differs from its enable in sleep");

  // Alert is a single-cycle pulse, so the controller sees one event per entry
  AST_ALERT_PULSE: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    ALERT_O |=> !ALERT_O)
    else $error("Alert held longer than one cycle");

  // A sleep request never touches the standby regulator setting
  AST_STBY_KEEP: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_reg == swsc_pkg::SWSC_NORMAL && cmd_ok && !SELF_TEST_I &&
     STATE_CODE_I == swsc_pkg::SWSC_REQ_SLEEP)
      |=> $stable(REG_EN_O[swsc_pkg::SWSC_BIT_STBY]))
    else $error("Standby regulator changed by sleep request");

  // Sleep supervision comes from the request, not from the normal setting
  AST_SUP_LOAD: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_reg == swsc_pkg::SWSC_NORMAL && cmd_ok && !SELF_TEST_I &&
     STATE_CODE_I == swsc_pkg::SWSC_REQ_SLEEP)
      |=> SUP_EN_O == $past(SLEEP_SUP_CFG_I))
    else $error("Sleep supervision not loaded");

  // Wake writes land on the very next edge
  AST_WAKE_WRITE: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_reg == swsc_pkg::SWSC_WAKE && REG_WR_I && !cmd_ok)
      |=> REG_EN_O == $past(REG_WDATA_I))
    else $error("Regulator write in wake not applied");

  // Supervision writes in wake are taken as well
  AST_SUP_WRITE: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_reg == swsc_pkg::SWSC_WAKE && SUP_WR_I && !cmd_ok)
      |=> SUP_EN_O == $past(SUP_WDATA_I))
    else $error("Supervision write in wake not applied");

  // Wake keeps the application safe on all three lines
  AST_SAFE_WAKE: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (state_reg == swsc_pkg::SWSC_WAKE)
      |-> !SAFE_STATE_CONTROL_O && !SAFE_STATE_ONE_O && !SAFE_STATE_TWO_O)
    else $error("Safe state high in wake");

endmodule // swsc_top
`default_nettype wire
